// ---- dv/serial_peer.sv ----
// far-side peer: open-drain line resolution and a bursty serial clock
`timescale 1ns/1ns
`default_nettype none
module serial_peer (
    // device drive in, resolved lines out
    input wire sw_pkg::pin_drive_t pin_drive,
    output logic                   sda,
    output logic                   scl
);
    logic sda_low = 1'b0;
    logic scl_drv = 1'b1;
    // pull-up wins unless a party pulls low
    assign sda = (pin_drive.dat_oe ? pin_drive.dat_o : 1'b1) & ~sda_low;
    assign scl = (pin_drive.clk_oe ? pin_drive.clk_o : 1'b1) & scl_drv;
    // clock runs only inside a frame, idle high between
    task automatic clock_out(input int k);
        // start off the sampling edge of the unit's clock
        #20;
        repeat (k) begin
            #160 scl_drv = 1'b0;
            #160 scl_drv = 1'b1;
        end
    endtask
endmodule // serial_peer
`default_nettype wire

// ---- dv/serial_wire_unit_bench.sv ----
// self-checking bench of the serial wire unit
`timescale 1ns/1ns
`default_nettype none
module serial_wire_unit_bench;
    logic               ref_clk = 1'b0;
    logic               sys_rst = 1'b1;
    logic               rd = 1'b0;
    logic               wr = 1'b0;
    logic               tick = 1'b0;
    logic [3:0]         adr = 4'h0;
    logic [31:0]        wd = 32'h00000000;
    logic [31:0]        rdat, q;
    logic               wreq, sda, scl, irq;
    sw_pkg::pin_drive_t pd;
    int                 n, error_cnt = 0, checks_done = 0;
    int                 n_tick = 0;
    logic               t_on = 1'b1;
    always #20 ref_clk = ~ref_clk;
    // random timer ticks; they must not count under the strobe source
    always @(posedge ref_clk) tick <= t_on & 1'($urandom);
    // ticks as the unit samples them, for the timer source check
    always @(posedge ref_clk) if (tick) n_tick++;
    serial_wire_unit dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wreq),
        .timer_match(tick), .serial_data_in_pin(sda),
        .serial_clock_pin(scl), .pin_drive(pd), .irq(irq));
    serial_peer peer (.pin_drive(pd), .sda(sda), .scl(scl));
    task automatic report_and_stop;
        if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    function automatic logic [31:0] exp_cnt(input int k);
        return 32'(k % 16);
    endfunction
    // one transfer, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= ~w;
        // held until a rising edge samples waitrequest low
        do begin
            @(posedge ref_clk);
        end while (wreq !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    // wait, bounded, for the clock-line pull to reach a level
    task automatic wait_clk(input logic v);
        int t = 0;
        while (pd.clk_oe !== v && t < 30) begin
            @(posedge ref_clk);
            t++;
        end
        cmp("clk_oe", {31'h0, v}, {31'h0, pd.clk_oe});
    endtask
    initial begin
        void'($urandom(21102));
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        bus(0, sw_pkg::ADDR_CTRL, 0);
        cmp("ctrl", {24'h0, sw_pkg::CTRL_RST}, q);
        bus(0, 4'h2, 0);
        cmp("unmapped", sw_pkg::UNMAPPED_RD, q);
        repeat (12) bus(1, sw_pkg::ADDR_CTRL,
            {8'h80, 8'($urandom), 10'h0, 2'($urandom), 4'h0});
        bus(1, sw_pkg::ADDR_CTRL, 32'h80000000);
        bus(1, sw_pkg::ADDR_STATUS, 32'h3);
        bus(1, sw_pkg::ADDR_MASK, 32'h2);
        // strobes count n, then wrap to raise the overflow
        n = $urandom_range(14, 1);
        repeat (n) bus(1, sw_pkg::ADDR_CTRL, 32'h2);
        bus(0, sw_pkg::ADDR_DATA, 0);
        cmp("count", exp_cnt(n), {28'h0, q[11:8]});
        cmp("irq early", 0, irq);
        repeat (16 - n) bus(1, sw_pkg::ADDR_CTRL, 32'h2);
        bus(0, sw_pkg::ADDR_STATUS, 0);
        cmp("status", 32'h2, q);
        cmp("irq", 1, irq);
        bus(1, sw_pkg::ADDR_MASK, 0);
        cmp("irq masked", 0, irq);
        bus(1, sw_pkg::ADDR_STATUS, 32'h2);
        // two-wire start holds the clock until its flag is cleared
        bus(1, sw_pkg::ADDR_DATA, 32'hFF);
        bus(1, sw_pkg::ADDR_CTRL, 32'h80660020);
        peer.sda_low <= 1'b1;
        wait_clk(1'b1);
        peer.sda_low <= 1'b0;
        bus(1, sw_pkg::ADDR_STATUS, 32'h1);
        wait_clk(1'b0);
        // external clock: five rising edges advance the counter
        bus(1, sw_pkg::ADDR_CTRL, 32'h80660028);
        peer.clock_out(5);
        repeat (4) @(posedge ref_clk);
        bus(0, sw_pkg::ADDR_DATA, 0);
        cmp("ext count", exp_cnt(5), {28'h0, q[11:8]});
        // timer source: the counter follows the offered ticks
        t_on <= 1'b0;
        repeat (2) @(posedge ref_clk);
        n_tick = 0;
        bus(1, sw_pkg::ADDR_CTRL, 32'h00000004);
        t_on <= 1'b1;
        repeat (40) @(posedge ref_clk);
        t_on <= 1'b0;
        repeat (3) @(posedge ref_clk);
        bus(0, sw_pkg::ADDR_DATA, 0);
        cmp("timer count", exp_cnt(5 + n_tick), {28'h0, q[11:8]});
        report_and_stop();
    end
    // watchdog well past the whole sequence
    initial begin
        #400000;
        error_cnt++;
        report_and_stop();
    end
endmodule // serial_wire_unit_bench
`default_nettype wire

// ---- dv/serial_wire_unit_chk.sv ----
// checker: bus handshake and wire-mode pin relations
`timescale 1ns/1ns
`default_nettype none
module serial_wire_unit_chk #(
    parameter int CNT_W = 4
) (
    // clock, reset, bus, pins
    input wire logic               ref_clk,
    input wire logic               sys_rst,
    input wire logic [3:0]         avs_address,
    input wire logic               avs_read,
    input wire logic               avs_write,
    input wire logic [31:0]        avs_writedata,
    input wire logic [31:0]        avs_readdata,
    input wire logic               avs_waitrequest,
    input wire sw_pkg::pin_drive_t pin_drive,
    input wire logic               irq
);
    // taken writes; pins show a control write two edges later
    wire logic       tk = avs_write && avs_waitrequest;
    wire logic       ctl = tk && avs_address == sw_pkg::ADDR_CTRL;
    wire logic       tw = ctl && avs_writedata[31] && avs_writedata[5];
    wire logic [7:0] pb = avs_writedata[23:16];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    chk_req_answer: assert property ((avs_read || avs_write)
        && avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
    chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("wait low twice");
    chk_unmapped_zero: assert property (avs_read && avs_waitrequest
        && avs_address[1:0] != 2'h0 |=> avs_readdata == 32'h0)
        else $error("unmapped read");
    chk_tw_pullup: assert property (tw |-> ##2
        !pin_drive.dat_pu && !pin_drive.clk_pu) else $error("pull-up on");
    chk_dat_dir: assert property (tw && !pb[5] |-> ##2
        !pin_drive.dat_oe && !pin_drive.dat_o) else $error("data driven");
    chk_dat_pull: assert property (tw && pb[5] && !pb[1] |-> ##2
        pin_drive.dat_oe) else $error("data not pulled");
    chk_clk_pull: assert property (tw && pb[6] && !pb[2] |-> ##2
        pin_drive.clk_oe) else $error("clock not pulled");
    chk_do_dir: assert property (ctl && avs_writedata[31]
        && avs_writedata[5:4] == 2'h1 |-> ##2 pin_drive.do_oe == pb[4])
        else $error("data out direction");
    chk_off_port: assert property (ctl && avs_writedata[31]
        && avs_writedata[5:4] == 2'h0 && !avs_writedata[0]
        |-> ##2 pin_drive.clk_oe == pb[6] && pin_drive.clk_o == pb[2])
        else $error("port mode pins");
    chk_mask_quiet: assert property (tk && avs_writedata[1:0] == 2'h0
        && avs_address == sw_pkg::ADDR_MASK |-> ##2 !irq)
        else $error("masked irq");
    cov_hold: cover property (tw ##2 pin_drive.clk_oe);
    cov_irq: cover property ($rose(irq));
    cov_read: cover property (avs_read && !avs_waitrequest);
endmodule // serial_wire_unit_chk
bind serial_wire_unit serial_wire_unit_chk #(.CNT_W(CNT_W)) chk (.*);
`default_nettype wire

// ---- hdl/serial_wire_unit.sv ----
// serial wire unit: wire modes, clock sources, shift register and counter
//
// Implementation choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module serial_wire_unit #(
    parameter int CNT_W = 4
) (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    // avalon-mm slave
    input  wire logic [3:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    // timer compare-match tick, same clock domain
    input  wire logic              timer_match,
    // pins: data out, serial data in / sda, serial clock pin / scl
    input  wire logic              serial_data_in_pin,
    input  wire logic              serial_clock_pin,
    output sw_pkg::pin_drive_t     pin_drive,
    // interrupt
    output logic                   irq
);
    // register map, byte addresses on the avalon side
    //   0x0 control: [5:4] wire mode, [3:2] clock source,
    //       [1] strobe or clock select, [0] clock pin toggle;
    //       bit 31 set also loads the port byte from [23:16]
    //   0x4 data: write [7:0] loads the shift register,
    //       read gives the counter in [11:8], shift register in [7:0]
    //   0x8 status: [0] start flag, [1] overflow flag, write one clears
    //   0xC mask: same layout as status, gates the irq level
    // port byte: [0] data out value, [1] data value, [2] clock value,
    //   [4] data out direction, [5] data direction, [6] clock direction
    // bus timing: a request is taken on the edge that finds waitrequest
    //   high; waitrequest drops for exactly one cycle after it, and the
    //   read word stands from then until the next read is taken
    // writes act on the taking edge; the master must still hold the
    //   request until it sees waitrequest low, and must drop it then,
    //   or a second copy of the write is taken one cycle later
    // pins: every pin output is registered, so a register write shows
    //   on the pins one cycle after it lands, but the clock value and the output latch show as they land in three- and two-wire modes,
    //   as do the start flag in both two-wire modes and the overflow flag in the hold mode, through the clock hold; pin inputs pass two
    //   flops and an edge detector, which costs two to three cycles
    // limitation: the serial clock pin is oversampled, so it must stay
    //   well below a quarter of ref_clk or edges are lost
    // two-wire drive: dat_o and clk_o stay low and the enables mean
    //   pull the line low; a released line is left to the pull-up
    // hazard: a control write with both bit 31 and the toggle bit set
    //   loads the port byte but sets its clock value bit to the inverse of the old one
    // the data out pin has no pull-up control here; its pad owns it
    // unmapped reads return zero and unmapped writes are dropped, so
    //   software probing the map cannot disturb the unit

    // whole unit state; one comb block builds the next copy
    typedef struct packed {
        logic [1:0]       wm;
        logic [1:0]       cs;
        logic             clk_sel;
        logic [7:0]       port;
        logic [7:0]       shreg;
        logic [CNT_W-1:0] cnt;
        logic             sif;
        logic             oif;
        logic [1:0]       mask;
        logic             do_latch;
        logic [1:0]       sda_s;
        logic [1:0]       scl_s;
        logic             sda_d;
        logic             scl_d;
        logic             ack;
        logic [31:0]      rdata;
        sw_pkg::pin_drive_t drv;
        logic             irq;
    } state_t;

    state_t st_ff;
    state_t nxt_st;

    // msb-first shift with input sample
    function automatic logic [7:0] shift_in(input logic [7:0] v,
                                            input logic       b);
        shift_in = {v[6:0], b};
    endfunction

    // write strobe aimed at one register address
    function automatic logic wr_hit(input logic       w,
                                    input logic [3:0] a,
                                    input logic [3:0] r);
        wr_hit = w && (a == r);
    endfunction

    // next state: bus, synchronisers, clocking, pin drive
    always_comb begin
        logic sda;
        logic scl;
        logic scl_rise;
        logic scl_fall;
        logic strobe;
        logic toggle;
        logic tick;
        logic out_tick;
        logic wr;
        logic start_ev;
        logic ovf_ev;
        logic [7:0] cw;
        logic [CNT_W-1:0] cnt_nx;
        logic dat_now;
        logic wm_two;
        sda = 1'b0;
        scl = 1'b0;
        scl_rise = 1'b0;
        scl_fall = 1'b0;
        strobe = 1'b0;
        toggle = 1'b0;
        tick = 1'b0;
        out_tick = 1'b0;
        wr = 1'b0;
        start_ev = 1'b0;
        ovf_ev = 1'b0;
        cw = 8'h00;
        cnt_nx = st_ff.cnt;
        dat_now = 1'b0;
        wm_two = 1'b0;
        nxt_st = st_ff;

        // two-flop synchronisers; logic reads only the second stage
        nxt_st.sda_s = {st_ff.sda_s[0], serial_data_in_pin};
        nxt_st.scl_s = {st_ff.scl_s[0], serial_clock_pin};
        sda = st_ff.sda_s[1];
        scl = st_ff.scl_s[1];
        nxt_st.sda_d = sda;
        nxt_st.scl_d = scl;
        scl_rise = scl & ~st_ff.scl_d;
        scl_fall = ~scl & st_ff.scl_d;

        // single-cycle answer: waitrequest low one cycle after request
        nxt_st.ack = (avs_read | avs_write) & ~st_ff.ack;
        wr = avs_write & ~st_ff.ack;
        cw = avs_writedata[7:0];
        if (wr_hit(wr, avs_address, sw_pkg::ADDR_CTRL)) begin
            nxt_st.wm = cw[sw_pkg::WM_HI:sw_pkg::WM_LO];
            nxt_st.cs = cw[sw_pkg::CS_HI:sw_pkg::CS_LO];
            nxt_st.clk_sel = cw[sw_pkg::STROBE_B];
            strobe = cw[sw_pkg::STROBE_B] & ~cw[sw_pkg::CS_HI];
            toggle = cw[sw_pkg::TOGGLE_B];
        end
        wm_two = st_ff.wm[1];

        // port register lives in the upper half of the control word
        if (wr_hit(wr, avs_address, sw_pkg::ADDR_CTRL) && avs_writedata[31])
            nxt_st.port = avs_writedata[23:16];
        if (toggle)
            nxt_st.port[sw_pkg::PV_CLK] = ~st_ff.port[sw_pkg::PV_CLK];

        // clock source table, by the two source bits:
        //   00 software strobe: a control write with the strobe bit set
        //   01 timer compare-match pulses from the same clock domain
        //   10 serial clock pin, shift on its rising edge
        //   11 serial clock pin, shift on its falling edge
        //   with 1x and the select bit set, the toggle bit clocks instead
        unique case (st_ff.cs)
            2'b00: tick = strobe;
            2'b01: tick = timer_match;
            default: begin
                // strobe bit picks toggle clocking over the pin
                if (st_ff.clk_sel)
                    tick = toggle;
                else
                    tick = st_ff.cs[0] ? scl_fall : scl_rise;
            end
        endcase
        // opposite edge for the output latch when pin clocked
        if (st_ff.cs[1] && !st_ff.clk_sel)
            out_tick = st_ff.cs[0] ? scl_rise : scl_fall;

        if (wr_hit(wr, avs_address, sw_pkg::ADDR_DATA))
            nxt_st.shreg = cw;
        else if (tick)
            nxt_st.shreg = shift_in(st_ff.shreg, sda);
        cnt_nx = st_ff.cnt + CNT_W'(1);
        if (tick) begin
            nxt_st.cnt = cnt_nx;
            ovf_ev = (cnt_nx == '0);
        end

        // transparent latch for software/timer and toggle clocking, else edge latched
        if (!st_ff.cs[1] || st_ff.clk_sel)
            nxt_st.do_latch = nxt_st.shreg[7];
        else if (out_tick)
            nxt_st.do_latch = st_ff.shreg[7];

        // start: sda falls while scl high, only in an active mode
        // both inputs are only synchronised, not filtered, so a glitch shorter
        // than a cycle that a sampling edge catches can still fake a start
        start_ev = (st_ff.wm != 2'b00) & scl & st_ff.sda_d & ~sda;

        // flags: set wins over write-one-to-clear
        // the set is applied last, so an event in the clearing cycle
        // is never lost to a late clear
        if (wr_hit(wr, avs_address, sw_pkg::ADDR_STATUS)) begin
            if (cw[sw_pkg::SIF_B])
                nxt_st.sif = 1'b0;
            if (cw[sw_pkg::OIF_B])
                nxt_st.oif = 1'b0;
        end
        if (start_ev)
            nxt_st.sif = 1'b1;
        if (ovf_ev)
            nxt_st.oif = 1'b1;
        if (wr_hit(wr, avs_address, sw_pkg::ADDR_MASK))
            nxt_st.mask = cw[1:0];
        nxt_st.irq = |({nxt_st.oif, nxt_st.sif} & nxt_st.mask);

        // pin drive per wire mode
        // the hold terms use the next flag values, so the clock line
        // is grabbed in the same cycle the flag becomes visible
        nxt_st.drv = '0;
        dat_now = nxt_st.do_latch;
        unique case (sw_pkg::wire_mode_t'(st_ff.wm))
            sw_pkg::WM_OFF: begin
                // plain port control, no serial override
                nxt_st.drv.do_o   = st_ff.port[sw_pkg::PV_DO];
                nxt_st.drv.do_oe  = st_ff.port[sw_pkg::DD_DO];
                nxt_st.drv.dat_o  = st_ff.port[sw_pkg::PV_DAT];
                nxt_st.drv.dat_oe = st_ff.port[sw_pkg::DD_DAT];
                nxt_st.drv.clk_o  = st_ff.port[sw_pkg::PV_CLK];
                nxt_st.drv.clk_oe = st_ff.port[sw_pkg::DD_CLK];
            end
            sw_pkg::WM_THREE: begin
                nxt_st.drv.do_o   = dat_now;
                nxt_st.drv.do_oe  = st_ff.port[sw_pkg::DD_DO];
                nxt_st.drv.dat_o  = st_ff.port[sw_pkg::PV_DAT];
                nxt_st.drv.dat_oe = st_ff.port[sw_pkg::DD_DAT];
                nxt_st.drv.clk_o  = nxt_st.port[sw_pkg::PV_CLK];
                nxt_st.drv.clk_oe = st_ff.port[sw_pkg::DD_CLK];
            end
            default: begin
                // open drain on data and clock: drive low only, enable by direction
                nxt_st.drv.do_o   = st_ff.port[sw_pkg::PV_DO];
                nxt_st.drv.do_oe  = st_ff.port[sw_pkg::DD_DO];
                nxt_st.drv.dat_oe = st_ff.port[sw_pkg::DD_DAT]
                    & (~dat_now | ~st_ff.port[sw_pkg::PV_DAT]);
                nxt_st.drv.clk_oe = st_ff.port[sw_pkg::DD_CLK]
                    & (~nxt_st.port[sw_pkg::PV_CLK] | nxt_st.sif
                    | (st_ff.wm[0] & nxt_st.oif));
            end
        endcase
        // pull-ups only on inputs outside two-wire modes
        nxt_st.drv.dat_pu = ~wm_two & ~st_ff.port[sw_pkg::DD_DAT]
            & st_ff.port[sw_pkg::PV_DAT];
        nxt_st.drv.clk_pu = ~wm_two & ~st_ff.port[sw_pkg::DD_CLK]
            & st_ff.port[sw_pkg::PV_CLK];
        // read word captured on the taking edge only; it then stands
        // until the next read, whatever the master does meanwhile
        if (!st_ff.ack && avs_read) begin
            unique case (avs_address)
                sw_pkg::ADDR_CTRL:
                    nxt_st.rdata = {8'h00, st_ff.port, 8'h00,
                                    2'b00, st_ff.wm, st_ff.cs,
                                    st_ff.clk_sel, 1'b0};
                sw_pkg::ADDR_DATA:
                    nxt_st.rdata = 32'({st_ff.cnt, st_ff.shreg});
                sw_pkg::ADDR_STATUS:
                    nxt_st.rdata = {30'h00000000, st_ff.oif, st_ff.sif};
                sw_pkg::ADDR_MASK:
                    nxt_st.rdata = {30'h00000000, st_ff.mask};
                default:
                    nxt_st.rdata = sw_pkg::UNMAPPED_RD;
            endcase
        end
    end

    // state register with synchronous reset
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // every output comes straight from a state flop
    assign avs_readdata    = st_ff.rdata;
    assign avs_waitrequest = ~st_ff.ack;
    assign pin_drive       = st_ff.drv;
    assign irq             = st_ff.irq;
endmodule // serial_wire_unit
`default_nettype wire

// ---- hdl/sw_pkg.sv ----
// package: register map, field layout and types of the serial wire unit
package sw_pkg;
    // register byte addresses (word aligned)
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_DATA   = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam logic [3:0] ADDR_MASK   = 4'hC;
    localparam logic [3:0] ADDR_PORT   = 4'h0;
    // control register fields
    localparam int WM_HI     = 5;
    localparam int WM_LO     = 4;
    localparam int CS_HI     = 3;
    localparam int CS_LO     = 2;
    localparam int STROBE_B  = 1;
    localparam int TOGGLE_B  = 0;
    // status bit positions
    localparam int SIF_B     = 0;
    localparam int OIF_B     = 1;
    // port register (data out, data pin, clock pin) fields
    localparam int PV_DO     = 0;
    localparam int PV_DAT    = 1;
    localparam int PV_CLK    = 2;
    localparam int DD_DO     = 4;
    localparam int DD_DAT    = 5;
    localparam int DD_CLK    = 6;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] PORT_RST = 8'h00;
    localparam logic [31:0] UNMAPPED_RD = 32'h00000000;

    typedef enum logic [1:0] {
        WM_OFF, WM_THREE, WM_TWO, WM_TWO_HOLD
    } wire_mode_t;

    // pin group carrier: output value, output enable, pull-up
    typedef struct packed {
        logic do_o;
        logic do_oe;
        logic dat_o;
        logic dat_oe;
        logic dat_pu;
        logic clk_o;
        logic clk_oe;
        logic clk_pu;
    } pin_drive_t;
endpackage : sw_pkg
